// ### verilog/tmpra_pkg.sv
package tmpra_pkg;
  // Result encoding limits, in whole degrees.
  localparam logic signed [7:0] TMPRA_MAX_C      = 8'sh7F;
  localparam logic signed [7:0] TMPRA_MIN_C      = 8'shBF;
  localparam logic [7:0]        TMPRA_HIGH_POR   = 8'h7F;
  localparam logic [7:0]        TMPRA_LOW_POR    = 8'hC9;
  localparam logic [7:0]        TMPRA_ZERO       = 8'h00;
  // Raw converter width: signed quarter degrees.
  localparam int                TMPRA_RAW_W      = 12;
  localparam int                TMPRA_FRAC_W     = 2;
  localparam int                TMPRA_NCH        = 2;
  // Status byte bit positions.
  localparam int                TMPRA_ST_R2LOW   = 0;
  localparam int                TMPRA_ST_R2HIGH  = 1;
  localparam int                TMPRA_ST_R1LOW   = 2;
  localparam int                TMPRA_ST_R1HIGH  = 3;
  localparam int                TMPRA_ST_OPEN    = 4;
  localparam int                TMPRA_ST_BUSY    = 7;

  // Raw conversion result from the converter.
  typedef struct packed {
    logic                          valid;
    logic                          chan;
    logic signed [TMPRA_RAW_W-1:0] quarter_deg;
  } tmpra_conv_t;

  // Limit write from the serial front end.
  typedef struct packed {
    logic       valid;
    logic       chan;
    logic       is_high;
    logic [7:0] value;
  } tmpra_limit_wr_t;
endpackage

// ### verilog/tmpra_core.sv
// Contract
// - Results are 8-bit 1C/LSB, round half up, saturate +127, clamp -65.
// - Keep high and low alarm limits for each of the two remote channels.
// - Result at or past a channel limit asserts the alert output.
// - Low limits reset to 1100 1001, minus 55 degrees.
// - Open diode is tested at every conversion start; fault flag updated.
// - No diode fault shown before the first conversion starts.
// - Anode shorted to cathode or ground gives a remote reading of zero.
// - Anode shorted to supply gives +127 on remote and local and alarms.
// - Alert stays latched until the alert response address is read.
// - Status read clears flags except those whose fault persists; here only a persisting open fault keeps its flag, limit flags clear.
`timescale 1ns/1ps
module tmpra_core (
  // Clock and reset.
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       clk_en,
  // Converter side.
  input  wire tmpra_pkg::tmpra_conv_t     conv_in,
  input  wire logic                       conv_start,
  input  wire logic                       conv_busy,
  input  wire logic                       remote_diode_open_pin,
  input  wire logic                       remote_diode_short_gnd_pin,
  input  wire logic                       remote_diode_short_vcc_pin,
  // Serial front end.
  input  wire tmpra_pkg::tmpra_limit_wr_t limit_wr,
  input  wire logic                       status_read_done,
  input  wire logic                       ara_read_done,
  input  wire logic                       alert_mask,
  // Results.
  output logic [7:0]                      remote_temp_q [2],
  output logic [7:0]                      local_temp_q,
  output logic [7:0]                      high_alarm_limit_q [2],
  output logic [7:0]                      low_alarm_limit_q [2],
  output logic [7:0]                      status_byte,
  // Open-drain alert pin, pulled low while driven.
  output logic                            alert_out,
  output logic                            alert_oe
);

  // Quarter-degree saturation bounds, derived from the encoded limits so the two can never drift apart.
  localparam logic signed [tmpra_pkg::TMPRA_RAW_W-1:0] RAW_MAX =
    (tmpra_pkg::TMPRA_RAW_W)'(tmpra_pkg::TMPRA_MAX_C) <<< tmpra_pkg::TMPRA_FRAC_W;
  localparam logic signed [tmpra_pkg::TMPRA_RAW_W-1:0] RAW_MIN =
    (tmpra_pkg::TMPRA_RAW_W)'(tmpra_pkg::TMPRA_MIN_C) <<< tmpra_pkg::TMPRA_FRAC_W;

  // Rounds half up (+0.5 becomes +1, -0.5 becomes 0) and clamps.
  function automatic logic [7:0] tmpra_encode(input logic signed [tmpra_pkg::TMPRA_RAW_W-1:0] q);
    logic signed [tmpra_pkg::TMPRA_RAW_W:0] r;
    r = ($signed({q[tmpra_pkg::TMPRA_RAW_W-1], q}) + 13'sd2) >>> tmpra_pkg::TMPRA_FRAC_W;
    if (q >= RAW_MAX) return tmpra_pkg::TMPRA_MAX_C;
    else if (q <= RAW_MIN) return tmpra_pkg::TMPRA_MIN_C;
    else return r[7:0];
  endfunction

  // Pin levels cross into the clock domain through two flops.
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else if (clk_en) begin
      pin_s1_q <= {remote_diode_short_vcc_pin, remote_diode_short_gnd_pin, remote_diode_open_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic diode_open;
  logic diode_gnd;
  logic diode_vcc;
  assign diode_open = pin_s2_q[0];
  assign diode_gnd  = pin_s2_q[1];
  assign diode_vcc  = pin_s2_q[2];

  // Encoded value of the incoming result, with short forcing applied.
  logic [7:0] new_val;
  always_comb begin
    new_val = tmpra_encode(conv_in.quarter_deg);
    if (diode_vcc) new_val = tmpra_pkg::TMPRA_MAX_C;
    else if (diode_gnd) new_val = tmpra_pkg::TMPRA_ZERO;
  end

  // Result registers; the local register has no converter input and only loads +127 on the supply short.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      remote_temp_q[0] <= tmpra_pkg::TMPRA_ZERO;
      remote_temp_q[1] <= tmpra_pkg::TMPRA_ZERO;
      local_temp_q     <= tmpra_pkg::TMPRA_ZERO;
    end else if (clk_en) begin
      if (conv_in.valid) remote_temp_q[conv_in.chan] <= new_val;
      if (diode_vcc) local_temp_q <= tmpra_pkg::TMPRA_MAX_C;
    end
  end

  // Limit registers written by the host.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < tmpra_pkg::TMPRA_NCH; i++) begin
        high_alarm_limit_q[i] <= tmpra_pkg::TMPRA_HIGH_POR;
        low_alarm_limit_q[i]  <= tmpra_pkg::TMPRA_LOW_POR;
      end
    end else if (clk_en && limit_wr.valid) begin
      if (limit_wr.is_high) high_alarm_limit_q[limit_wr.chan] <= limit_wr.value;
      else low_alarm_limit_q[limit_wr.chan] <= limit_wr.value;
    end
  end

  // Compare only on a stored result, so alarms follow the conversion rate.
  logic hi_hit;
  logic lo_hit;
  assign hi_hit = conv_in.valid && ($signed(new_val) >= $signed(high_alarm_limit_q[conv_in.chan]));
  assign lo_hit = conv_in.valid && ($signed(new_val) <= $signed(low_alarm_limit_q[conv_in.chan]));

  // Status flags: set wins over the read clear; persisting open fault stays.
  logic [3:0] lim_flags_q;
  logic       open_flag_q;
  logic       started_q;
  logic [3:0] lim_set;
  always_comb begin
    lim_set = 4'h0;
    if (conv_in.valid && conv_in.chan) begin
      lim_set[tmpra_pkg::TMPRA_ST_R2HIGH] = hi_hit;
      lim_set[tmpra_pkg::TMPRA_ST_R2LOW]  = lo_hit;
    end else if (conv_in.valid) begin
      lim_set[tmpra_pkg::TMPRA_ST_R1HIGH] = hi_hit;
      lim_set[tmpra_pkg::TMPRA_ST_R1LOW]  = lo_hit;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lim_flags_q <= 4'h0;
      open_flag_q <= 1'b0;
      started_q   <= 1'b0;
    end else if (clk_en) begin
      lim_flags_q <= (status_read_done ? 4'h0 : lim_flags_q) | lim_set;
      if (conv_start) begin
        started_q   <= 1'b1;
        open_flag_q <= diode_open;
      end else if (status_read_done && !diode_open) begin
        open_flag_q <= 1'b0;
      end
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[tmpra_pkg::TMPRA_ST_R1HIGH:tmpra_pkg::TMPRA_ST_R2LOW] = lim_flags_q;
    status_byte[tmpra_pkg::TMPRA_ST_OPEN] = open_flag_q;
    status_byte[tmpra_pkg::TMPRA_ST_BUSY] = conv_busy;
  end

  // Alert latch; the status clear does not release it, only the response read.
  logic alert_q;
  logic alert_evt;
  assign alert_evt = !alert_mask && ((|lim_set) || (conv_start && diode_open));
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) alert_q <= 1'b0;
    else if (clk_en) begin
      if (alert_evt) alert_q <= 1'b1;
      else if (ara_read_done) alert_q <= 1'b0;
    end
  end
  assign alert_out = 1'b0;
  assign alert_oe  = alert_q;

  // Checks.
  sequence s_new_high;
    conv_in.valid && !alert_mask && hi_hit && clk_en;
  endsequence
  alert_on_high_a: assert property (@(posedge clk_sys) disable iff (!nrst) s_new_high |=> alert_oe)
    else $error("Alert not raised on high limit hit.");
  alert_holds_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (alert_oe && !ara_read_done && clk_en) |=> alert_oe)
    else $error("Alert dropped without response read.");
  no_early_fault_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !started_q |-> !status_byte[tmpra_pkg::TMPRA_ST_OPEN])
    else $error("Fault shown before first conversion.");
  vcc_short_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && diode_vcc && conv_in.valid) |=> remote_temp_q[$past(conv_in.chan)] == tmpra_pkg::TMPRA_MAX_C)
    else $error("Supply short not reported as full scale.");
  gnd_short_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && !diode_vcc && diode_gnd && conv_in.valid) |=> remote_temp_q[$past(conv_in.chan)] == 8'h00)
    else $error("Ground short not reported as zero.");
  clamp_range_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $signed(remote_temp_q[0]) >= $signed(tmpra_pkg::TMPRA_MIN_C))
    else $error("Result below clamp.");
  open_persist_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && open_flag_q && diode_open && !conv_start) |=> open_flag_q)
    else $error("Persisting fault cleared.");
  limits_por_a: assert property (@(posedge clk_sys) $rose(nrst) |->
    high_alarm_limit_q[0] == tmpra_pkg::TMPRA_HIGH_POR && low_alarm_limit_q[1] == tmpra_pkg::TMPRA_LOW_POR)
    else $error("Limit reset values wrong.");
  other_por_a: assert property (@(posedge clk_sys) $rose(nrst) |->
    high_alarm_limit_q[1] == tmpra_pkg::TMPRA_HIGH_POR && low_alarm_limit_q[0] == tmpra_pkg::TMPRA_LOW_POR)
    else $error("Other limit reset values wrong.");
  // Low-side hit mirrors the high side; the mask is the only thing allowed to hold the alert back.
  sequence s_new_low;
    conv_in.valid && !alert_mask && lo_hit && clk_en;
  endsequence
  alert_on_low_a: assert property (@(posedge clk_sys) disable iff (!nrst) s_new_low |=> alert_oe)
    else $error("Alert not raised on low limit hit.");
  // The open test has two outcomes at a start: anode high shows the fault, anode low clears it.
  sequence s_start_open;
    clk_en && conv_start && diode_open;
  endsequence
  sequence s_start_closed;
    clk_en && conv_start && !diode_open;
  endsequence
  open_at_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_start_open |=> status_byte[tmpra_pkg::TMPRA_ST_OPEN])
    else $error("Open diode not flagged at conversion start.");
  closed_at_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_start_closed |=> !status_byte[tmpra_pkg::TMPRA_ST_OPEN])
    else $error("Stale open fault kept after a clean start.");
  flags_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && !conv_in.valid && !status_read_done) |=> $stable(lim_flags_q))
    else $error("Limit flags moved without a new result.");
  read_clears_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && status_read_done && !conv_in.valid) |=> lim_flags_q == 4'h0)
    else $error("Status read left limit flags set.");
  local_full_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clk_en && diode_vcc) |=> local_temp_q == tmpra_pkg::TMPRA_MAX_C)
    else $error("Supply short not shown on local channel.");
endmodule // tmpra_core

// ### testbench/tmpra_conv_model.sv
`timescale 1ns/1ps
// Converter model: start pulse, three busy cycles, then one valid result pulse.
module tmpra_conv_model (
  // Clock and reset.
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // Request from the bench.
  input  wire logic                          go,
  input  wire logic                          chan,
  input  wire logic signed [11:0]            qd,
  // Converter outputs.
  output tmpra_pkg::tmpra_conv_t             conv_in,
  output logic                               conv_start,
  output logic                               conv_busy
);
  logic [1:0] cnt_q;
  // Data toggles outside the valid pulse, so a design that reads stale data is caught.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q      <= 2'h0;
      conv_start <= 1'b0;
      conv_in    <= '0;
    end else begin
      conv_start          <= go;
      cnt_q               <= go ? 2'h3 : (cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0;
      conv_in.valid       <= (cnt_q == 2'h1);
      conv_in.chan        <= chan;
      conv_in.quarter_deg <= (cnt_q == 2'h1) ? qd : ~conv_in.quarter_deg;
    end
  end
  assign conv_busy = (cnt_q != 2'h0);
endmodule // tmpra_conv_model

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0, nrst = 1'b0, go = 1'b0, chan = 1'b0, st_rd = 1'b0, ara_rd = 1'b0;
  logic opn = 1'b1, sgnd = 1'b0, svcc = 1'b0, conv_start, conv_busy, alert_out, alert_oe;
  logic signed [11:0] qd = 12'h000;
  logic [7:0] rt [2], lt, hl [2], ll [2], st;
  tmpra_pkg::tmpra_conv_t conv_in;
  tmpra_pkg::tmpra_limit_wr_t lw = '0;
  int fails = 0, checks = 0, cyc = 0;
  logic signed [11:0] qv [8] = '{12'h1FA, 12'h208, 12'h065, 12'h002, 12'hFFE, 12'hFFD, 12'hF25, 12'hEE8};
  logic [7:0] ev [8] = '{8'h7F, 8'h7F, 8'h19, 8'h01, 8'h00, 8'hFF, 8'hC9, 8'hBF};
  tmpra_conv_model i_model (.clk_sys(clk_sys), .nrst(nrst), .go(go), .chan(chan), .qd(qd),
    .conv_in(conv_in), .conv_start(conv_start), .conv_busy(conv_busy));
  tmpra_core i_dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .conv_in(conv_in), .conv_start(conv_start),
    .conv_busy(conv_busy), .remote_diode_open_pin(opn), .remote_diode_short_gnd_pin(sgnd),
    .remote_diode_short_vcc_pin(svcc), .limit_wr(lw), .status_read_done(st_rd), .ara_read_done(ara_rd),
    .alert_mask(1'b0), .remote_temp_q(rt), .local_temp_q(lt), .high_alarm_limit_q(hl),
    .low_alarm_limit_q(ll), .status_byte(st), .alert_out(alert_out), .alert_oe(alert_oe));
  // Free-running clock; the timeout stops a hung run well past the expected length.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One conversion on a channel; the result lands well within six cycles.
  task automatic conv(logic c, logic signed [11:0] q);
    @(posedge clk_sys) begin go <= 1'b1; chan <= c; qd <= q; end
    @(posedge clk_sys) go <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic lim(logic c, logic h, logic [7:0] v);
    @(posedge clk_sys) lw <= '{1'b1, c, h, v};
    @(posedge clk_sys) lw <= '0;
    repeat (2) @(posedge clk_sys);
  endtask
  // Status read or alert response read, as a single-cycle pulse.
  task automatic rd(logic ara);
    @(posedge clk_sys) if (ara) ara_rd <= 1'b1; else st_rd <= 1'b1;
    @(posedge clk_sys) begin ara_rd <= 1'b0; st_rd <= 1'b0; end
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic pins(logic o, logic g, logic v);
    @(posedge clk_sys) begin opn <= o; sgnd <= g; svcc <= v; end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_por;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 2; i++) begin
      check(hl[i], 8'h7F);
      check(ll[i], 8'hC9);
    end
    check(st[4], 1'b0);
    conv(1'b0, 12'h000);
    check(st[4], 1'b1);
    rd(1'b0);
    check(st[4], 1'b1);
    pins(1'b0, 1'b0, 1'b0);
    rd(1'b0);
    conv(1'b0, 12'h000);
    check(st[4], 1'b0);
    rd(1'b1);
    check(alert_oe, 1'b0);
    $display("test por done");
  endtask
  task automatic t_round;
    for (int i = 0; i < 8; i++) begin
      conv(1'b1, qv[i]);
      check(rt[1], ev[i]);
    end
    check(st[1], 1'b1);
    check(st[0], 1'b1);
    rd(1'b0);
    rd(1'b1);
    $display("test round done");
  endtask
  task automatic t_alarm;
    lim(1'b0, 1'b1, 8'h3F);
    check(hl[0], 8'h3F);
    lim(1'b1, 1'b1, 8'hB0);
    check(hl[1], 8'hB0);
    lim(1'b0, 1'b0, 8'hE0);
    check(ll[0], 8'hE0);
    check(st[1], 1'b0);
    check(alert_oe, 1'b0);
    conv(1'b0, 12'h0FF);
    check(rt[0], 8'h40);
    check(st[3], 1'b1);
    check(alert_oe, 1'b1);
    check(alert_out, 1'b0);
    rd(1'b0);
    check(st[3], 1'b0);
    check(alert_oe, 1'b1);
    rd(1'b1);
    check(alert_oe, 1'b0);
    $display("test alarm done");
  endtask
  task automatic t_short;
    // Channel 0 limits are 3F and E0: the raw reading alone would trip high, the forced zero must not.
    pins(1'b0, 1'b1, 1'b0);
    conv(1'b0, 12'h0FF);
    check(rt[0], 8'h00);
    check(st[3], 1'b0);
    check(alert_oe, 1'b0);
    // A raw zero stays below 3F, so only the forced full scale can raise the alarm here.
    pins(1'b0, 1'b0, 1'b1);
    conv(1'b0, 12'h000);
    check(rt[0], 8'h7F);
    check(lt, 8'h7F);
    check(alert_oe, 1'b1);
    $display("test short done");
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_por();
    t_round();
    t_alarm();
    t_short();
    print_verdict();
  end
endmodule // tb
